// ==== rtl/sfc_codec.sv ====
`timescale 1ns/1ns
`default_nettype none
module sfc_codec
    import sfc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic [1:0]  frame_mode_select,
    input  wire logic        link_is_spi,
    input  wire logic        rx_frame_format_select,
    input  wire logic        ser_rx_valid,
    input  wire logic [7:0]  ser_rx_data,
    output logic             ser_rx_ready,
    output logic             ser_tx_valid,
    output logic [7:0]       ser_tx_data,
    input  wire logic        ser_tx_ready,
    output logic             pay_valid,
    output logic [7:0]       pay_data,
    input  wire logic        pay_ready,
    output logic             req_valid,
    output logic [7:0]       req_type,
    output logic [7:0]       req_id,
    output logic             frame_err,
    input  wire logic        done_valid,
    input  wire logic [7:0]  done_status,
    output logic             done_ready,
    input  wire logic        dlv_start,
    input  wire logic [15:0] dlv_len,
    output logic             dlv_start_ready,
    input  wire logic        dlv_valid,
    input  wire logic [7:0]  dlv_data,
    output logic             dlv_ready
);
    sfc_dec_e    dst_q;
    sfc_src_e    src_q;
    logic        esc_q, pay_valid_q, req_valid_q, err_q, pend_q;
    logic [15:0] len_q, pos_q, dcnt_q;
    logic [7:0]  sum_q, type_q, id_q, pay_q, rtype_q, rid_q, prt_q, pid_q, rstat_q;

    sfc_enc_if enc_bus ();

    // mode 2 escaping only exists on the uart, spi falls back to plain framing
    logic framed, esc_on, rx_take, resync, is_esc, ub_valid;
    assign framed  = frame_mode_select != MODE_TRANSP;
    assign esc_on  = frame_mode_select == MODE_API_ESC && !link_is_spi;
    assign ser_rx_ready = !pay_valid_q || pay_ready;
    assign rx_take = ser_rx_valid && ser_rx_ready;
    assign resync  = framed && rx_take && ser_rx_data == SFC_DELIM
                     && (esc_on || dst_q == D_HUNT);
    assign is_esc  = esc_on && rx_take && ser_rx_data == SFC_ESC && !esc_q && dst_q != D_HUNT;
    assign ub_valid = framed && rx_take && !resync && !is_esc && dst_q != D_HUNT;

    logic [7:0] ubyte, sum_nx;
    logic       last_data, good_now, bad_now, pay_push;
    assign ubyte     = esc_q ? (ser_rx_data ^ SFC_XOR) : ser_rx_data;
    assign sum_nx    = sum_q + ubyte;
    assign last_data = (pos_q + LEN_ONE) == len_q;
    assign good_now  = ub_valid && dst_q == D_CSUM && sum_nx == SFC_CSUM_GOOD;
    assign bad_now   = ub_valid && dst_q == D_CSUM && sum_nx != SFC_CSUM_GOOD;
    assign pay_push  = (!framed && rx_take) || (ub_valid && dst_q == D_DATA);

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            dst_q <= D_HUNT;
            esc_q <= 1'b0;
        end else if (resync) begin
            dst_q <= D_LENH;
            esc_q <= 1'b0;
        end else if (is_esc) begin
            esc_q <= 1'b1;
        end else if (ub_valid) begin
            esc_q <= 1'b0;
            case (dst_q)
                D_LENH:  dst_q <= D_LENL;
                D_LENL:  dst_q <= ({len_q[15:8], ubyte} == 16'h0000) ? D_CSUM : D_DATA;
                D_DATA:  dst_q <= last_data ? D_CSUM : D_DATA;
                default: dst_q <= D_HUNT;
            endcase
        end
    end

    // length counts unescaped bytes, checksum excluded
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            len_q  <= 16'h0000;
            pos_q  <= 16'h0000;
            sum_q  <= 8'h00;
            type_q <= 8'h00;
            id_q   <= 8'h00;
        end else if (ub_valid) begin
            if (dst_q == D_LENH) begin
                len_q[15:8] <= ubyte;
            end
            if (dst_q == D_LENL) begin
                len_q[7:0] <= ubyte;
                pos_q      <= 16'h0000;
                sum_q      <= 8'h00;
                type_q     <= 8'h00;
                id_q       <= SFC_ID_NONE;
            end
            if (dst_q == D_DATA) begin
                sum_q <= sum_nx;
                pos_q <= pos_q + LEN_ONE;
                if (pos_q == 16'h0000) begin
                    type_q <= ubyte;
                end
                if (pos_q == LEN_ONE) begin
                    id_q <= ubyte;
                end
            end
        end
    end

    // payload bytes stream out early; only req_valid lets logic act on them
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pay_valid_q <= 1'b0;
            pay_q       <= 8'h00;
        end else if (pay_push) begin
            pay_valid_q <= 1'b1;
            pay_q       <= framed ? ubyte : ser_rx_data;
        end else if (pay_ready) begin
            pay_valid_q <= 1'b0;
        end
    end
    assign pay_valid = pay_valid_q;
    assign pay_data  = pay_q;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            req_valid_q <= 1'b0;
            err_q       <= 1'b0;
            req_type    <= 8'h00;
            req_id      <= 8'h00;
        end else begin
            req_valid_q <= good_now;
            err_q       <= bad_now;
            if (good_now) begin
                req_type <= type_q;
                req_id   <= id_q;
            end
        end
    end
    assign req_valid = req_valid_q;
    assign frame_err = err_q;

    logic       is_at, is_tx, is_rat, need_rsp, rsp_go, dlv_go, adv;
    logic [7:0] rsp_code;
    assign is_at    = type_q == T_AT || type_q == T_AT_Q;
    assign is_tx    = type_q == T_TX || type_q == T_TX_X;
    assign is_rat   = type_q == T_RAT;
    assign need_rsp = is_rat || ((is_at || is_tx) && id_q != SFC_ID_NONE);
    assign rsp_code = is_rat ? T_RAT_RSP : (is_tx ? T_TX_STAT : T_AT_RSP);
    assign done_ready      = framed && src_q == S_IDLE && enc_bus.idle;
    assign dlv_start_ready = done_ready && !(done_valid && pend_q);
    assign rsp_go = done_valid && done_ready && pend_q;
    assign dlv_go = dlv_start && dlv_start_ready;
    assign adv    = enc_bus.bvalid && enc_bus.bready;

    // a new good request needing a response in the cycle the old one is answered keeps pending set
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pend_q <= 1'b0;
            prt_q  <= 8'h00;
            pid_q  <= 8'h00;
        end else if (good_now && need_rsp) begin
            pend_q <= 1'b1;
            prt_q  <= rsp_code;
            pid_q  <= id_q;
        end else if (rsp_go) begin
            pend_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            src_q   <= S_IDLE;
            rtype_q <= 8'h00;
            rid_q   <= 8'h00;
            rstat_q <= 8'h00;
            dcnt_q  <= 16'h0000;
        end else if (src_q == S_IDLE) begin
            if (rsp_go) begin
                src_q   <= S_TYPE;
                rtype_q <= prt_q;
                rid_q   <= pid_q;
                rstat_q <= done_status;
            end else if (dlv_go) begin
                src_q  <= S_DTYPE;
                dcnt_q <= dlv_len;
            end
        end else if (adv) begin
            case (src_q)
                S_TYPE:  src_q <= S_ID;
                S_ID:    src_q <= S_STAT;
                S_DTYPE: src_q <= (dcnt_q == 16'h0000) ? S_IDLE : S_DDATA;
                S_DDATA: begin
                    dcnt_q <= dcnt_q - LEN_ONE;
                    src_q  <= (dcnt_q == LEN_ONE) ? S_IDLE : S_DDATA;
                end
                default: src_q <= S_IDLE;
            endcase
        end
    end

    assign enc_bus.start  = rsp_go || dlv_go;
    assign enc_bus.len    = rsp_go ? RSP_LEN : (dlv_len + LEN_ONE);
    assign enc_bus.bvalid = (src_q == S_DDATA) ? dlv_valid : (src_q != S_IDLE);
    assign enc_bus.bdata  = (src_q == S_TYPE)  ? rtype_q :
                            (src_q == S_ID)    ? rid_q :
                            (src_q == S_STAT)  ? rstat_q :
                            (src_q == S_DTYPE) ? (rx_frame_format_select ? T_RX_X : T_RX) :
                            dlv_data;
    assign dlv_ready = framed ? (src_q == S_DDATA && enc_bus.bready) : ser_tx_ready;

    logic       enc_valid;
    logic [7:0] enc_data;
    sfc_frame_encoder u_enc (
        .mclk      (mclk),
        .resetn    (resetn),
        .escape_en (esc_on),
        .e         (enc_bus.enc),
        .tx_valid  (enc_valid),
        .tx_data   (enc_data),
        .tx_ready  (ser_tx_ready && framed)
    );
    assign ser_tx_valid = framed ? enc_valid : dlv_valid;
    assign ser_tx_data  = framed ? enc_data : dlv_data;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    sequence s_check_byte;
        dst_q == D_CSUM && ub_valid;
    endsequence
    sequence s_good_seen;
        s_check_byte ##0 sum_nx == SFC_CSUM_GOOD;
    endsequence

    a_good_frame_req: assert property (s_good_seen |=> req_valid && !frame_err)
        else $error("good frame not reported");
    a_bad_frame_drop: assert property (
        (s_check_byte ##0 sum_nx != SFC_CSUM_GOOD) |=> frame_err && !req_valid && !$rose(pend_q))
        else $error("bad frame acted on");
    a_zero_id_quiet: assert property (
        (s_good_seen ##0 id_q == SFC_ID_NONE && !is_rat && !pend_q && !rsp_go) |=> !pend_q)
        else $error("response not suppressed");
    a_remote_always: assert property (
        (s_good_seen ##0 is_rat) |=> pend_q && prt_q == T_RAT_RSP)
        else $error("remote response missing");
    a_tx_status_code: assert property (
        (s_good_seen ##0 is_tx && id_q != SFC_ID_NONE) |=> pend_q && prt_q == T_TX_STAT)
        else $error("tx status not armed");
    a_hunt_drops: assert property (
        (framed && dst_q == D_HUNT && rx_take && ser_rx_data != SFC_DELIM)
        |=> dst_q == D_HUNT && !$rose(pay_valid))
        else $error("byte before delimiter used");
    a_raw_delim_restart: assert property (
        (esc_on && rx_take && ser_rx_data == SFC_DELIM) |=> dst_q == D_LENH && !esc_q)
        else $error("raw delimiter did not restart");
    a_rsp_sequence: assert property (
        rsp_go |=> src_q == S_TYPE && enc_bus.bdata == $past(prt_q) && rid_q == $past(pid_q))
        else $error("response framing wrong");
    a_deliver_type: assert property (
        (src_q == S_DTYPE && rx_frame_format_select) |-> enc_bus.bdata == T_RX_X)
        else $error("delivery type wrong");
endmodule : sfc_codec
`default_nettype wire

// ==== shared/sfc_pkg.sv ====
`default_nettype none
package sfc_pkg;
    localparam logic [7:0]  SFC_DELIM       = 8'h7E;
    localparam logic [7:0]  SFC_ESC         = 8'h7D;
    localparam logic [7:0]  SFC_XOR         = 8'h20;
    localparam logic [7:0]  SFC_FLOW_RESUME = 8'h11;
    localparam logic [7:0]  SFC_FLOW_PAUSE  = 8'h13;
    localparam logic [7:0]  SFC_CSUM_GOOD   = 8'hFF;
    localparam logic [7:0]  SFC_ID_NONE     = 8'h00;
    localparam logic [7:0]  T_AT            = 8'h08;
    localparam logic [7:0]  T_AT_Q          = 8'h09;
    localparam logic [7:0]  T_TX            = 8'h10;
    localparam logic [7:0]  T_TX_X          = 8'h11;
    localparam logic [7:0]  T_RAT           = 8'h17;
    localparam logic [7:0]  T_AT_RSP        = 8'h88;
    localparam logic [7:0]  T_TX_STAT       = 8'h8B;
    localparam logic [7:0]  T_RX            = 8'h90;
    localparam logic [7:0]  T_RX_X          = 8'h91;
    localparam logic [7:0]  T_RAT_RSP       = 8'h97;
    localparam logic [1:0]  MODE_TRANSP     = 2'h0;
    localparam logic [1:0]  MODE_API        = 2'h1;
    localparam logic [1:0]  MODE_API_ESC    = 2'h2;
    localparam logic [15:0] RSP_LEN         = 16'h0003;
    localparam logic [15:0] LEN_ONE         = 16'h0001;

    typedef enum logic [2:0] {
        D_HUNT = 3'b000, D_LENH = 3'b001, D_LENL = 3'b010, D_DATA = 3'b011, D_CSUM = 3'b100
    } sfc_dec_e;
    typedef enum logic [2:0] {
        E_IDLE = 3'b000, E_LENH = 3'b001, E_LENL = 3'b010, E_DATA = 3'b011, E_CSUM = 3'b100
    } sfc_enc_e;
    typedef enum logic [2:0] {
        S_IDLE = 3'b000, S_TYPE = 3'b001, S_ID = 3'b010, S_STAT = 3'b011,
        S_DTYPE = 3'b100, S_DDATA = 3'b101
    } sfc_src_e;

    function automatic logic sfc_needs_esc(input logic [7:0] b);
        return b == SFC_DELIM || b == SFC_ESC || b == SFC_FLOW_RESUME || b == SFC_FLOW_PAUSE;
    endfunction : sfc_needs_esc
endpackage : sfc_pkg
`default_nettype wire

// ==== shared/sfc_enc_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface sfc_enc_if;
    logic        start;
    logic [15:0] len;
    logic        bvalid;
    logic [7:0]  bdata;
    logic        bready;
    logic        idle;
    modport src (output start, len, bvalid, bdata, input bready, idle);
    modport enc (input start, len, bvalid, bdata, output bready, idle);
endinterface : sfc_enc_if
`default_nettype wire

// ==== rtl/sfc_frame_encoder.sv ====
`timescale 1ns/1ns
`default_nettype none
module sfc_frame_encoder
    import sfc_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic       escape_en,
    sfc_enc_if.enc          e,
    output logic            tx_valid,
    output logic [7:0]      tx_data,
    input  wire logic       tx_ready
);
    sfc_enc_e    st_q, st_d;
    logic [15:0] len_q, cnt_q;
    logic [7:0]  sum_q, cur_q;
    logic        have_q, raw_q, esc_ph_q;

    logic       need, byte_done, can_load, load;
    logic [7:0] load_byte;
    // the delimiter goes out raw, every other byte may be escaped
    assign need      = escape_en && !raw_q && sfc_needs_esc(cur_q);
    assign tx_valid  = have_q;
    assign tx_data   = esc_ph_q ? (cur_q ^ SFC_XOR) : (need ? SFC_ESC : cur_q);
    assign byte_done = have_q && tx_ready && (!need || esc_ph_q);
    assign can_load  = !have_q || byte_done;
    assign e.idle    = (st_q == E_IDLE) && can_load;
    assign e.bready  = (st_q == E_DATA) && can_load;
    assign load      = can_load && (st_q != E_IDLE || e.start) && (st_q != E_DATA || e.bvalid);
    assign load_byte = (st_q == E_IDLE) ? SFC_DELIM :
                       (st_q == E_LENH) ? len_q[15:8] :
                       (st_q == E_LENL) ? len_q[7:0] :
                       (st_q == E_DATA) ? e.bdata : (SFC_CSUM_GOOD - sum_q);

    always_comb begin
        st_d = st_q;
        case (st_q)
            E_IDLE:  st_d = E_LENH;
            E_LENH:  st_d = E_LENL;
            E_LENL:  st_d = (len_q == 16'h0000) ? E_CSUM : E_DATA;
            E_DATA:  st_d = (cnt_q == LEN_ONE) ? E_CSUM : E_DATA;
            E_CSUM:  st_d = E_IDLE;
            default: st_d = E_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_q <= E_IDLE;
        end else if (load) begin
            st_q <= st_d;
        end
    end

    // length and sum run on unescaped bytes only
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            len_q <= 16'h0000;
            cnt_q <= 16'h0000;
            sum_q <= 8'h00;
        end else if (load) begin
            if (st_q == E_IDLE) begin
                len_q <= e.len;
                sum_q <= 8'h00;
            end
            if (st_q == E_LENL) begin
                cnt_q <= len_q;
            end
            if (st_q == E_DATA) begin
                sum_q <= sum_q + e.bdata;
                cnt_q <= cnt_q - LEN_ONE;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cur_q    <= 8'h00;
            have_q   <= 1'b0;
            raw_q    <= 1'b0;
            esc_ph_q <= 1'b0;
        end else if (load) begin
            cur_q    <= load_byte;
            have_q   <= 1'b1;
            raw_q    <= (st_q == E_IDLE);
            esc_ph_q <= 1'b0;
        end else if (byte_done) begin
            have_q   <= 1'b0;
            esc_ph_q <= 1'b0;
        end else if (have_q && tx_ready && need) begin
            esc_ph_q <= 1'b1;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    a_esc_pair_follows: assert property (
        (tx_valid && tx_ready && tx_data == SFC_ESC && !raw_q && escape_en)
        |=> tx_valid && tx_data == ($past(cur_q) ^ SFC_XOR))
        else $error("escape marker not followed by flipped byte");
    a_len_msb_first: assert property (
        (load && st_q == E_LENH) |=> cur_q == len_q[15:8] && $past(st_q) == E_LENH)
        else $error("length high byte not sent first");
    a_csum_value: assert property (
        (load && st_q == E_CSUM) |=> (cur_q + $past(sum_q)) == SFC_CSUM_GOOD)
        else $error("checksum byte wrong");
    a_held_byte_stable: assert property (
        (have_q && !byte_done) |=> $stable(cur_q) && $stable(cnt_q))
        else $error("byte or count moved during escape");
endmodule : sfc_frame_encoder
`default_nettype wire

// ==== tb/sfc_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module sfc_host_model (
    input  wire logic       mclk,
    input  wire logic       slow,
    input  wire logic       ser_rx_ready,
    output logic            ser_rx_valid,
    output logic [7:0]      ser_rx_data,
    input  wire logic       ser_tx_valid,
    input  wire logic [7:0] ser_tx_data,
    output logic            ser_tx_ready
);
    logic [7:0] txq[$];
    logic [1:0] ph = 2'h0;
    initial begin
        ser_rx_valid = 1'b0;
        ser_rx_data  = 8'h00;
    end
    // byte held until the edge that sees ready high
    task automatic send(input logic [7:0] b);
        @(negedge mclk);
        ser_rx_valid = 1'b1;
        ser_rx_data  = b;
        #1;
        while (ser_rx_ready !== 1'b1) begin
            @(negedge mclk);
            #1;
        end
        @(posedge mclk);
    endtask : send
    // released line shows the inverse, not a stale byte
    task automatic idle();
        @(negedge mclk);
        ser_rx_valid = 1'b0;
        ser_rx_data  = ~ser_rx_data;
    endtask : idle
    always @(negedge mclk) begin
        ph           <= ph + 2'h1;
        ser_tx_ready <= !slow || ph[0];
    end
    // raw wire bytes kept, escapes included, so the bench can check them
    always @(posedge mclk) begin
        if (ser_tx_valid === 1'b1 && ser_tx_ready) txq.push_back(ser_tx_data);
    end
endmodule : sfc_host_model
`default_nettype wire

// ==== tb/serial_api_frame_codec_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module serial_api_frame_codec_tb;
    import sfc_pkg::*;
    typedef logic [7:0] sfc_bq_t[$];
    typedef struct {
        logic [1:0] mode;
        logic       spi;
        logic [7:0] typ;
        logic [7:0] id;
        logic [7:0] dat;
        logic       bad;
        logic [7:0] code;
    } sfc_row_s;
    logic        mclk = 1'b0;
    logic        pay_ready = 1'b1;
    logic        resetn, link_is_spi, rx_frame_format_select, stall;
    logic        done_valid, dlv_start, dlv_valid, ser_rx_valid, ser_rx_ready, ser_tx_valid;
    logic        ser_tx_ready, pay_valid, req_valid, frame_err, done_ready, dlv_start_ready;
    logic        dlv_ready;
    logic [1:0]  frame_mode_select;
    logic [7:0]  done_status, dlv_data, ser_rx_data, ser_tx_data, pay_data, req_type, req_id;
    logic [15:0] dlv_len;
    int          mismatches, cmp_count, nreq, nerr;
    sfc_bq_t     payq;
    sfc_row_s    rows[9] = '{
        '{2'h1, 1'b0, 8'h08, 8'h05, 8'h42, 1'b0, 8'h88}, '{2'h1, 1'b0, 8'h09, 8'h13, 8'h7E, 1'b0, 8'h88},
        '{2'h2, 1'b0, 8'h10, 8'h11, 8'h7D, 1'b0, 8'h8B}, '{2'h2, 1'b0, 8'h11, 8'h00, 8'h13, 1'b0, 8'h00},
        '{2'h2, 1'b0, 8'h17, 8'h00, 8'h20, 1'b0, 8'h97}, '{2'h2, 1'b0, 8'h08, 8'h22, 8'h33, 1'b1, 8'h00},
        '{2'h2, 1'b1, 8'h17, 8'h7D, 8'h01, 1'b0, 8'h97}, '{2'h1, 1'b0, 8'h08, 8'h00, 8'h44, 1'b0, 8'h00},
        '{2'h1, 1'b0, 8'h55, 8'h07, 8'h01, 1'b0, 8'h00}};

    sfc_codec dut (.mclk(mclk), .resetn(resetn), .frame_mode_select(frame_mode_select),
        .link_is_spi(link_is_spi), .rx_frame_format_select(rx_frame_format_select),
        .ser_rx_valid(ser_rx_valid), .ser_rx_data(ser_rx_data), .ser_rx_ready(ser_rx_ready),
        .ser_tx_valid(ser_tx_valid), .ser_tx_data(ser_tx_data), .ser_tx_ready(ser_tx_ready),
        .pay_valid(pay_valid), .pay_data(pay_data), .pay_ready(pay_ready),
        .req_valid(req_valid), .req_type(req_type), .req_id(req_id), .frame_err(frame_err),
        .done_valid(done_valid), .done_status(done_status), .done_ready(done_ready),
        .dlv_start(dlv_start), .dlv_len(dlv_len), .dlv_start_ready(dlv_start_ready),
        .dlv_valid(dlv_valid), .dlv_data(dlv_data), .dlv_ready(dlv_ready));
    sfc_host_model host (.mclk(mclk), .slow(stall), .ser_rx_ready(ser_rx_ready),
        .ser_rx_valid(ser_rx_valid), .ser_rx_data(ser_rx_data), .ser_tx_valid(ser_tx_valid),
        .ser_tx_data(ser_tx_data), .ser_tx_ready(ser_tx_ready));

    always #4 mclk = ~mclk;
    always @(negedge mclk) pay_ready <= !stall || !pay_ready;
    always @(posedge mclk) begin
        if (pay_valid === 1'b1 && pay_ready) payq.push_back(pay_data);
        if (req_valid === 1'b1) nreq++;
        if (frame_err === 1'b1) nerr++;
    end

    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk8
    task automatic chkq(input sfc_bq_t got, input sfc_bq_t exp);
        chk8(8'(got.size()), 8'(exp.size()));
        foreach (exp[k]) chk8(k < got.size() ? got[k] : ~exp[k], exp[k]);
    endtask : chkq
    // ready checked just after the falling edge, where it has settled
    task automatic wait_on(input int s);
        int n;
        n = 0;
        #1;
        while ((s == 0 ? done_ready : s == 1 ? dlv_start_ready : dlv_ready) !== 1'b1 && n < 200) begin
            @(negedge mclk);
            #1;
            n++;
        end
        if (n >= 200) mismatches++;
        @(posedge mclk);
    endtask : wait_on
    function automatic sfc_bq_t frame(input sfc_bq_t body, input logic esc, input logic bad);
        sfc_bq_t     f;
        logic [7:0]  s;
        logic [15:0] n;
        s = 8'h00;
        n = 16'(body.size());
        f = '{8'h7E};
        foreach (body[k]) s += body[k];
        body.push_front(n[7:0]);
        body.push_front(n[15:8]);
        body.push_back((8'hFF - s) ^ {7'h00, bad});
        foreach (body[k]) begin
            if (esc && body[k] inside {8'h7E, 8'h7D, 8'h11, 8'h13}) begin
                f.push_back(8'h7D);
                f.push_back(body[k] ^ 8'h20);
            end else begin
                f.push_back(body[k]);
            end
        end
        return f;
    endfunction : frame
    task automatic put(input sfc_bq_t f);
        foreach (f[k]) host.send(f[k]);
        host.idle();
    endtask : put

    // roughly twenty times the expected run
    initial begin
        #100000;
        mismatches++;
        end_sim();
    end
    initial begin
        sfc_row_s r;
        sfc_bq_t  body;
        logic     esc;
        int       n0, e0;
        {resetn, link_is_spi, rx_frame_format_select, stall} = 4'h0;
        {done_valid, dlv_start, dlv_valid} = 3'h0;
        frame_mode_select = 2'h1;
        {done_status, dlv_data, dlv_len} = 32'h0;
        repeat (4) @(negedge mclk);
        chk8({5'h00, ser_rx_ready, pay_valid, req_valid | frame_err}, 8'h04);
        $display("reset done");
        repeat (4) @(negedge mclk);
        resetn = 1'b1;
        foreach (rows[i]) begin
            r = rows[i];
            stall = i[0];
            frame_mode_select = r.mode;
            link_is_spi = r.spi;
            esc = r.mode == 2'h2 && !r.spi;
            body = '{r.typ, r.id, r.dat};
            payq.delete();
            host.txq.delete();
            n0 = nreq;
            e0 = nerr;
            host.send(8'h55);
            put(frame(body, esc, r.bad));
            repeat (6) @(negedge mclk);
            chkq(payq, body);
            chk8(8'(nreq - n0), {7'h00, !r.bad});
            chk8(8'(nerr - e0), {7'h00, r.bad});
            if (!r.bad) chk8(req_type, r.typ);
            if (!r.bad) chk8(req_id, r.id);
            done_status = 8'(i) + 8'hA0;
            done_valid = 1'b1;
            wait_on(0);
            @(negedge mclk);
            done_valid = 1'b0;
            repeat (40) @(negedge mclk);
            body = '{r.code, r.id, done_status};
            if (r.code == 8'h00) body.delete();
            else body = frame(body, esc, 1'b0);
            chkq(host.txq, body);
            $display("row %0d done", i);
        end
        frame_mode_select = 2'h2;
        link_is_spi = 1'b0;
        stall = 1'b0;
        n0 = nreq;
        e0 = nerr;
        put('{8'h7E, 8'h00, 8'h05, 8'h08, 8'h01});
        put(frame('{8'h09, 8'h00, 8'h7E}, 1'b1, 1'b0));
        repeat (6) @(negedge mclk);
        chk8(8'(nreq - n0), 8'h01);
        chk8(8'(nerr - e0), 8'h00);
        chk8(req_type, 8'h09);
        $display("restart done");
        for (int f = 0; f < 2; f++) begin
            frame_mode_select = 2'(1 + f);
            rx_frame_format_select = f[0];
            stall = f[0];
            host.txq.delete();
            dlv_start = 1'b1;
            dlv_len = 16'h0002;
            wait_on(1);
            @(negedge mclk);
            dlv_start = 1'b0;
            body = '{8'h7E, 8'h31};
            foreach (body[k]) begin
                dlv_valid = 1'b1;
                dlv_data = body[k];
                wait_on(2);
                @(negedge mclk);
            end
            dlv_valid = 1'b0;
            dlv_data = 8'hCE;
            repeat (40) @(negedge mclk);
            body.push_front(f[0] ? 8'h91 : 8'h90);
            chkq(host.txq, frame(body, f[0], 1'b0));
            $display("delivery %0d done", f);
        end
        frame_mode_select = 2'h0;
        payq.delete();
        put('{8'h7E});
        repeat (4) @(negedge mclk);
        chkq(payq, '{8'h7E});
        host.txq.delete();
        dlv_valid = 1'b1;
        dlv_data = 8'h3C;
        wait_on(2);
        @(negedge mclk);
        dlv_valid = 1'b0;
        repeat (4) @(negedge mclk);
        chkq(host.txq, '{8'h3C});
        $display("transparent done");
        end_sim();
    end
endmodule : serial_api_frame_codec_tb
`default_nettype wire
